// file: verilog/pod_map.svh
// register map, field positions, reset values and encodings of the override block
// assumes an APB slave with 32-bit words, each register one aligned word
`ifndef POD_MAP_SVH
`define POD_MAP_SVH
`define POD_ADDR_MODE      12'h000
`define POD_ADDR_OVR_CTRL  12'h004
`define POD_ADDR_MAN_STATE 12'h008
`define POD_ADDR_IRQ_STAT  12'h00C
`define POD_ADDR_IRQ_MASK  12'h010
`define POD_ADDR_STATUS    12'h014
`define POD_ADDR_DUTY_BASE 12'h020
`define POD_OVR_RESET      6'h3F
`define POD_MAN_RESET      6'h00
`define POD_MODE_DOUBLE    2'h3
`define POD_MODE_UPDOWN    2'h2
`define POD_MODE_LSB       0
`define POD_EN_BIT         2
`define POD_CMPL_BIT       3
`define POD_POL_BIT        4
`define POD_IRQ_ZERO       0
`define POD_IRQ_PERIOD     1
`define POD_ZERO_COUNT     12'h000
`endif

// file: verilog/pod_pkg.sv
// types shared by the override block and its output stage
// assumes nothing beyond a SystemVerilog compiler
package pod_pkg;
    typedef enum logic [1:0] {
        pod_half_up   = 2'b01,
        pod_half_down = 2'b10
    } pod_half_t;
endpackage

// file: verilog/pod_out_stage.sv
// per-output override and complementary pairing stage, registered
// assumes pwm_raw comes from the duty comparators in the same clock domain
module pod_out_stage
    import pod_pkg::*;
#(
    parameter int N_OUT = 6
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [N_OUT-1:0] pwm_raw,
    input  wire logic [N_OUT-1:0] ovr_ctrl,
    input  wire logic [N_OUT-1:0] man_state,
    input  wire logic             complementary,
    input  wire logic             active_low,
    output logic      [N_OUT-1:0] pwm_out
);
    logic [N_OUT-1:0] next_active;

    // select source, then force even outputs to the inverse of their odd partner
    always_comb begin
        next_active = '0;
        for (int i = 0; i < N_OUT; i++) begin
            next_active[i] = ovr_ctrl[i] ? pwm_raw[i] : man_state[i];
        end
        if (complementary) begin
            for (int i = 0; i < N_OUT; i += 2) begin
                next_active[i] = ~next_active[i+1];
            end
        end
    end

    // one register so a register change reaches the pin on the next clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= next_active ^ {N_OUT{active_low}};
        end
    end
endmodule

// file: verilog/pod_top.sv
// pwm output override stage with double-update time base interrupts, APB slave
// assumes the time base counter and period come from the counting logic on mclk
// Contract
// - in mode 11 an interrupt event fires when the counter is zero and when it equals period.
// - double update exists only as a form of continuous up/down counting.
// - in double update duty values are taken at both interrupt points each period.
// - in double update the up and down halves may use different duty values.
// - an override bit of one lets the duty and time base logic drive that output.
// - an override bit of zero drives the output from its manual state bit.
// - when overridden, a manual bit of one is active and zero is inactive.
// - in complementary mode each even output is the inverse of its odd partner.
// - override control resets to all ones in six bits, upper two read zero.
// - manual state resets to all zeros in six bits, upper two read zero.
// - duty generation and override operate together on the same outputs.
// - outputs 2 to 5 reach port pins 4 to 7 when that pin direction bit is zero.
//
// The APB register port and the register addresses were chosen for this implementation.
`include "pod_map.svh"
module pod_top
    import pod_pkg::*;
#(
    parameter int N_OUT = 6,
    parameter int CNT_W = 12
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [CNT_W-1:0]  timebase_counter,
    input  wire logic [CNT_W-1:0]  timebase_period,
    input  wire logic              count_down,
    input  wire logic [3:0]        pin_direction_bit,
    input  wire logic [3:0]        port_latch,
    output logic      [N_OUT-1:0]  pwm_out,
    output logic      [3:0]        port_b_pin,
    output logic      [3:0]        port_b_oe_n,
    output logic      [1:0]        timebase_mode_field,
    output logic                   timebase_enable,
    output logic                   tb_event,
    output logic                   irq
);
    ////////////////////////////////////////////////////////////////////////////
    // register map, one aligned 32-bit word each, data in the low bits
    //   mode          field in bits 1:0, enable bit 2, pairing bit 3, polarity bit 4
    //   override      six control bits, one selects pwm and zero the manual bit
    //   manual state  six state bits, one is active and zero inactive
    //   irq status    zero match and period match flags, write one to clear
    //   irq mask      one enable per status flag
    //   status        outputs in bits 5:0, event pulse bit 6, down half bit 7
    //   duty          six buffers, one word apart from the duty base
    // an address outside the map answers with pslverr, drops writes and reads zero
    //
    // timing, counted from the edge at which the access phase first stands
    //   +1 edge   the write lands and pready rises with the read data
    //   +2 edges  the master sees pready and releases the bus
    //   a mode, override or manual state change reaches pwm_out one edge after it lands,
    //   and the port pins one edge later still
    //
    // limitation: the mode field is not guarded against a change while the
    // time base runs; software must disable first, or events may come early
    // or late for one period
    //
    // trade-off: every output is registered, which costs a cycle of latency
    // but keeps the pins free of decode glitches toward the power stage

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [4:0]       mode_reg;
    logic [N_OUT-1:0] ovr_ctrl;
    logic [N_OUT-1:0] man_state;
    logic [1:0]       irq_stat;
    logic [1:0]       irq_mask;
    logic [CNT_W-1:0] duty_buf [N_OUT];
    logic [CNT_W-1:0] duty_act [N_OUT];
    logic [N_OUT-1:0] pwm_raw;
    logic [N_OUT-1:0] stage_out;
    pod_half_t        half;
    logic             hit_zero;
    logic             hit_period;
    logic             zero_event;
    logic             period_event;
    logic             double_mode;
    logic             updown_mode;
    logic             wr_en;
    logic             rd_en;
    logic [31:0]      next_rdata;
    logic             next_err;

    // maps a byte address to a duty buffer index, or N_OUT when outside the window
    function automatic int duty_index(input logic [11:0] addr);
        int idx;
        idx = N_OUT;
        for (int i = 0; i < N_OUT; i++) begin
            if (addr == `POD_ADDR_DUTY_BASE + 12'(4 * i)) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    // the first cycle of the APB access phase, before pready, is the only cycle that commits
    assign wr_en = psel && penable && pwrite && !pready;
    assign rd_en = psel && penable && !pwrite && !pready;

    // one decode for the write strobe of every register except the duty buffers, so each register block reads alike
    function automatic logic reg_hit(input logic [11:0] addr);
        return wr_en && (paddr == addr);
    endfunction

    // picks the pwm output wired to a port pin; pins 4..7 carry outputs 2..5
    function automatic logic next_pin(input int p);
        return stage_out[p + 2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // time base event detection
    assign double_mode = mode_reg[`POD_MODE_LSB +: 2] == `POD_MODE_DOUBLE;
    assign updown_mode = mode_reg[`POD_MODE_LSB + 1];
    assign hit_zero    = timebase_counter == `POD_ZERO_COUNT;
    assign hit_period  = timebase_counter == timebase_period;

    // the two interrupt points; status, event pulse and duty transfer share them
    // so software never sees a flag for a point at which no duty value was taken
    assign zero_event   = timebase_enable && updown_mode && hit_zero;
    assign period_event = timebase_enable && double_mode && hit_period;

    // events only in up/down modes; double update adds the period-match event
    always_ff @(posedge mclk) begin
        if (rst) begin
            tb_event <= 1'b0;
        end else begin
            tb_event <= zero_event || period_event;
        end
    end

    // half-period tracker from count_down, read back as the down half bit of status
    always_ff @(posedge mclk) begin
        if (rst) begin
            half <= pod_half_up;
        end else begin
            half <= count_down ? pod_half_down : pod_half_up;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // duty transfer from buffers at the update points; while disabled the
    // buffers pass straight through so the first period starts with fresh values
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < N_OUT; i++) begin
                duty_act[i] <= '0;
            end
        end else if (!timebase_enable || zero_event || period_event) begin
            for (int i = 0; i < N_OUT; i++) begin
                duty_act[i] <= duty_buf[i];
            end
        end
    end

    // comparators; each output has its own duty value, compared while enabled
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            pwm_raw[i] = timebase_enable && (timebase_counter < duty_act[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers, one block each; unused upper bits are never stored
    // mode: field, enable, complementary pairing and output polarity
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_reg <= '0;
        end else if (reg_hit(`POD_ADDR_MODE)) begin
            mode_reg <= pwdata[4:0];
        end
    end

    // override control leaves reset all ones, so every output starts pwm driven
    always_ff @(posedge mclk) begin
        if (rst) begin
            ovr_ctrl <= `POD_OVR_RESET;
        end else if (reg_hit(`POD_ADDR_OVR_CTRL)) begin
            ovr_ctrl <= pwdata[N_OUT-1:0];
        end
    end

    // manual state leaves reset all zeros, so an override forces inactive
    always_ff @(posedge mclk) begin
        if (rst) begin
            man_state <= `POD_MAN_RESET;
        end else if (reg_hit(`POD_ADDR_MAN_STATE)) begin
            man_state <= pwdata[N_OUT-1:0];
        end
    end

    // interrupt mask, one bit per status flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_mask <= '0;
        end else if (reg_hit(`POD_ADDR_IRQ_MASK)) begin
            irq_mask <= pwdata[1:0];
        end
    end

    // duty buffers take writes at any time and reach the comparators only at
    // an update point or while disabled, so a half period never runs on a half-written value
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < N_OUT; i++) begin
                duty_buf[i] <= '0;
            end
        end else if (wr_en && duty_index(paddr) < N_OUT) begin
            duty_buf[duty_index(paddr)] <= pwdata[CNT_W-1:0];
        end
    end

    // the mode field is meant to change only while disabled; not enforced
    assign timebase_mode_field = mode_reg[`POD_MODE_LSB +: 2];
    assign timebase_enable     = mode_reg[`POD_EN_BIT];

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat <= '0;
        end else begin
            if (zero_event) begin
                irq_stat[`POD_IRQ_ZERO] <= 1'b1;
            end else if (reg_hit(`POD_ADDR_IRQ_STAT) && pwdata[`POD_IRQ_ZERO]) begin
                irq_stat[`POD_IRQ_ZERO] <= 1'b0;
            end
            if (period_event) begin
                irq_stat[`POD_IRQ_PERIOD] <= 1'b1;
            end else if (reg_hit(`POD_ADDR_IRQ_STAT) && pwdata[`POD_IRQ_PERIOD]) begin
                irq_stat[`POD_IRQ_PERIOD] <= 1'b0;
            end
        end
    end

    // level interrupt from registered status and mask
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; upper bits of the byte registers read zero
    always_comb begin
        next_rdata = '0;
        next_err   = 1'b0;
        unique case (paddr)
            `POD_ADDR_MODE:      next_rdata[4:0]       = mode_reg;
            `POD_ADDR_OVR_CTRL:  next_rdata[N_OUT-1:0] = ovr_ctrl;
            `POD_ADDR_MAN_STATE: next_rdata[N_OUT-1:0] = man_state;
            `POD_ADDR_IRQ_STAT:  next_rdata[1:0]       = irq_stat;
            `POD_ADDR_IRQ_MASK:  next_rdata[1:0]       = irq_mask;
            `POD_ADDR_STATUS:    next_rdata[N_OUT+1:0] = {half == pod_half_down, tb_event,
                                                          stage_out};
            default: begin
                if (duty_index(paddr) < N_OUT) begin
                    next_rdata[CNT_W-1:0] = duty_buf[duty_index(paddr)];
                end else begin
                    next_err = 1'b1;
                end
            end
        endcase
    end

    // one wait state: pready rises one cycle into the access phase and stands
    // one cycle; the spare cycle gives the read mux a full period to decode
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // read data stands only with pready and is zero otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= '0;
        end else begin
            prdata <= rd_en ? next_rdata : '0;
        end
    end

    // error answer for an address outside the map, reads and writes alike
    always_ff @(posedge mclk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= (rd_en || wr_en) && next_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // override stage
    pod_out_stage #(
        .N_OUT (N_OUT)
    ) u_stage (
        .mclk          (mclk),
        .rst           (rst),
        .pwm_raw       (pwm_raw),
        .ovr_ctrl      (ovr_ctrl),
        .man_state     (man_state),
        .complementary (mode_reg[`POD_CMPL_BIT]),
        .active_low    (mode_reg[`POD_POL_BIT]),
        .pwm_out       (stage_out)
    );

    assign pwm_out = stage_out;

    // port pins 4..7 carry outputs 2..5 when the direction bit selects output;
    // a pin set as input shows the latch value but its enable is released
    always_ff @(posedge mclk) begin
        if (rst) begin
            port_b_pin <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                port_b_pin[p] <= pin_direction_bit[p] ? port_latch[p] : next_pin(p);
            end
        end
    end

    // enable is active low and follows the direction bit, released in reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            port_b_oe_n <= '1;
        end else begin
            port_b_oe_n <= pin_direction_bit;
        end
    end
endmodule

// file: dv/pod_inverter.sv
// behavioural three-leg inverter power stage fed by the six override outputs
// assumes odd outputs drive high-side switches and even outputs low-side ones
module pod_inverter (
    input  wire logic [5:0] gate,
    output logic      [2:0] phase_high,
    output logic            shoot_through
);
    timeunit 1ns;
    timeprecision 1ps;
    // each leg follows its high-side switch
    assign phase_high = {gate[5], gate[3], gate[1]};
    // both switches of one leg on would short the supply
    assign shoot_through = (gate[0] & gate[1]) | (gate[2] & gate[3]) | (gate[4] & gate[5]);
endmodule

// file: dv/pod_properties.sv
// port-level checks of the override block, APB answer, events and pin routing
// assumes it is bound into pod_top with one clock domain on mclk
module pod_properties #(
    parameter int CNT_W = 12
) (
    input wire logic             mclk,
    input wire logic             rst,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [CNT_W-1:0] timebase_counter,
    input wire logic [CNT_W-1:0] timebase_period,
    input wire logic [3:0]       pin_direction_bit,
    input wire logic [3:0]       port_latch,
    input wire logic [5:0]       pwm_out,
    input wire logic [3:0]       port_b_pin,
    input wire logic [3:0]       port_b_oe_n,
    input wire logic [1:0]       timebase_mode_field,
    input wire logic             timebase_enable,
    input wire logic             tb_event
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // access phase waiting, then a one-cycle answer
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_done; pready ##1 !pready; endsequence
    logic dbl_on;
    assign dbl_on = timebase_enable && (timebase_mode_field == 2'h3);
    chk_ready_timing: assert property (s_wait |=> s_done) else $error("late pready");
    chk_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    chk_zero_event: assert property (dbl_on && timebase_counter == {CNT_W{1'b0}} |=> tb_event)
        else $error("no zero event");
    chk_period_event: assert property (dbl_on && timebase_counter == timebase_period |=> tb_event)
        else $error("no period event");
    chk_event_cause: assert property (tb_event |-> $past(timebase_enable && timebase_mode_field[1]))
        else $error("event outside up/down");
    chk_pin_enable: assert property (!$past(rst) |-> port_b_oe_n == $past(pin_direction_bit))
        else $error("pin enable");
    // pwm_out held steady so either registering point gives the same pin value
    chk_pin_value: assert property (!$past(rst) && $stable(pwm_out) |-> port_b_pin ==
        (($past(pin_direction_bit) & $past(port_latch)) | (~$past(pin_direction_bit) & pwm_out[5:2])))
        else $error("pin value");
endmodule
bind pod_top pod_properties #(.CNT_W(CNT_W)) u_props (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timebase_counter(timebase_counter), .timebase_period(timebase_period),
    .pin_direction_bit(pin_direction_bit), .port_latch(port_latch), .pwm_out(pwm_out),
    .port_b_pin(port_b_pin), .port_b_oe_n(port_b_oe_n),
    .timebase_mode_field(timebase_mode_field), .timebase_enable(timebase_enable),
    .tb_event(tb_event));

// file: dv/testbench.sv
// self-checking bench for pod_top: registers over APB, override, pins, interrupts
// assumes the design files and pod_map.svh are compiled first
`include "pod_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [5:0] x;} pod_row_t;
    logic        mclk, rst, psel, penable, pwrite, count_down, pready, pslverr, tb_event, irq;
    logic        ten, shoot, rerr;
    logic [11:0] paddr, cnt, per;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  dir, lat, pin, oe_n;
    logic [5:0]  pwm;
    logic [2:0]  leg;
    logic [1:0]  mode;
    int          err_count, total_checks;
    // write rows carry the readback and, with every output overridden, the pwm value
    pod_row_t rows [5] = '{'{`POD_ADDR_OVR_CTRL, 32'hFFFFFFC0, 6'h00},
        '{`POD_ADDR_MAN_STATE, 32'h000000FF, 6'h3F}, '{`POD_ADDR_MAN_STATE, 32'h15, 6'h15},
        '{`POD_ADDR_MAN_STATE, 32'h2A, 6'h2A}, '{`POD_ADDR_MAN_STATE, 32'h0, 6'h00}};
    pod_top dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timebase_counter(cnt), .timebase_period(per), .count_down(count_down),
        .pin_direction_bit(dir), .port_latch(lat), .pwm_out(pwm), .port_b_pin(pin),
        .port_b_oe_n(oe_n), .timebase_mode_field(mode), .timebase_enable(ten),
        .tb_event(tb_event), .irq(irq));
    pod_inverter u_inv (.gate(pwm), .phase_high(leg), .shoot_through(shoot));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until pready is sampled high, a bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("BAD pready expected 1 seen %b", pready);
            give_verdict;
        end
    endtask
    // register plus output stage need two edges; one spare
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cnt = 12'h005;
        per = 12'h009;
        count_down = 1'b0;
        dir = 4'h0;
        lat = 4'h0;
        err_count = 0;
        total_checks = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            check("readback", {26'h0, rows[i].x}, rd);
            settle;
            check("pwm_out", {26'h0, rows[i].x}, {26'h0, pwm});
        end
        $display("table test done");
        apb(1'b1, `POD_ADDR_MAN_STATE, 32'h3C);
        settle;
        check("pin", 32'hF, {28'h0, pin});
        check("oe_n", 32'h0, {28'h0, oe_n});
        @(posedge mclk);
        dir <= 4'hA; lat <= 4'h5;
        settle;
        check("pin", 32'h5, {28'h0, pin});
        check("oe_n", 32'hA, {28'h0, oe_n});
        $display("pin test done");
        // mode is set first, enable after, as software must
        apb(1'b1, `POD_ADDR_MODE, 32'h3);
        apb(1'b1, `POD_ADDR_MODE, 32'h7);
        check("mode field", 32'h3, {30'h0, mode});
        check("enable", 32'h1, {31'h0, ten});
        @(posedge mclk);
        cnt <= 12'h000;
        @(posedge mclk);
        cnt <= 12'h005;
        apb(1'b0, `POD_ADDR_IRQ_STAT, 32'h0);
        check("zero status", 32'h1, rd);
        check("masked irq", 32'h0, {31'h0, irq});
        apb(1'b1, `POD_ADDR_IRQ_MASK, 32'h3);
        settle;
        check("irq", 32'h1, {31'h0, irq});
        @(posedge mclk);
        cnt <= per;
        @(posedge mclk);
        cnt <= 12'h005;
        apb(1'b0, `POD_ADDR_IRQ_STAT, 32'h0);
        check("period status", 32'h3, rd);
        apb(1'b1, `POD_ADDR_IRQ_STAT, 32'h3);
        settle;
        check("cleared irq", 32'h0, {31'h0, irq});
        $display("interrupt test done");
        // while enabled, duty values reach the comparator only at an update point
        apb(1'b1, `POD_ADDR_MODE, 32'h3);
        apb(1'b1, `POD_ADDR_DUTY_BASE, 32'h6);
        apb(1'b1, `POD_ADDR_OVR_CTRL, 32'h1);
        apb(1'b1, `POD_ADDR_MAN_STATE, 32'h0);
        apb(1'b1, `POD_ADDR_MODE, 32'h7);
        settle;
        check("pwm duty", 32'h1, {26'h0, pwm});
        apb(1'b1, `POD_ADDR_DUTY_BASE, 32'h3);
        settle;
        check("duty held", 32'h1, {26'h0, pwm});
        @(posedge mclk);
        cnt <= per;
        @(posedge mclk);
        cnt <= 12'h005;
        settle;
        check("duty at period", 32'h0, {26'h0, pwm});
        // plain up/down counting keeps the zero event only
        apb(1'b1, `POD_ADDR_IRQ_STAT, 32'h3);
        apb(1'b1, `POD_ADDR_MODE, 32'h3);
        apb(1'b1, `POD_ADDR_MODE, 32'h2);
        apb(1'b1, `POD_ADDR_MODE, 32'h6);
        @(posedge mclk);
        cnt <= per;
        @(posedge mclk);
        cnt <= 12'h005;
        apb(1'b0, `POD_ADDR_IRQ_STAT, 32'h0);
        check("no period event", 32'h0, rd);
        @(posedge mclk);
        cnt <= 12'h000;
        @(posedge mclk);
        cnt <= 12'h005;
        apb(1'b0, `POD_ADDR_IRQ_STAT, 32'h0);
        check("updown zero", 32'h1, rd);
        $display("duty and mode test done");
        apb(1'b1, `POD_ADDR_MODE, 32'h2);
        apb(1'b1, `POD_ADDR_MODE, 32'h8);
        apb(1'b1, `POD_ADDR_MAN_STATE, 32'h3F);
        settle;
        check("paired pwm", 32'h2A, {26'h0, pwm});
        check("shoot", 32'h0, {31'h0, shoot});
        check("leg", 32'h7, {29'h0, leg});
        @(posedge mclk);
        count_down <= 1'b1;
        apb(1'b0, `POD_ADDR_STATUS, 32'h0);
        check("status", 32'hAA, rd);
        apb(1'b1, `POD_ADDR_MODE, 32'h18);
        settle;
        check("inverted pwm", 32'h15, {26'h0, pwm});
        apb(1'b0, 12'h7FC, 32'h0);
        check("unmapped err", 32'h1, {31'h0, rerr});
        check("unmapped data", 32'h0, rd);
        $display("pairing and unmapped test done");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        check("oe_n reset", 32'hF, {28'h0, oe_n});
        check("irq reset", 32'h0, {31'h0, irq});
        rst <= 1'b0;
        apb(1'b0, `POD_ADDR_OVR_CTRL, 32'h0);
        check("ovr reset", 32'h3F, rd);
        apb(1'b0, `POD_ADDR_MAN_STATE, 32'h0);
        check("man reset", 32'h0, rd);
        $display("reset test done");
        give_verdict;
    end
endmodule
